// ---- handover_pkg.sv ----
// package of constants for the bus handover arbiter
// assumes one common clock shared by the cpu and both requesting masters
// Functional notes
// [RQ1] in maximum configuration the cpu offers bus handover on two shared request/grant lines instead of hold/ack.
// [RQ2] each handover is three pulses on one line: request, grant, release.
// [RQ3] a requester opens a handover with a single pulse while it does not own the bus.
// [RQ4] the cpu answers on the same line at the end of the current bus cycle or idle clock.
// [RQ5] at the grant the cpu has floated its bus outputs and detaches from the command decoder the next clock.
// [RQ6] while held off the execution unit keeps running queued instructions until it needs the bus or the queue empties.
// [RQ7] the requester ends its tenure with a second pulse and the cpu takes the bus back on the next clock.
// [RQ8] all pulses are driven and sampled on one common clock.
// [RQ9] line 0 wins over line 1 when both request in the same clock.
// [RQ10] a held-back line 1 request is granted one or two clocks after line 0 releases; the code adds two ST_XFER clocks and the latency floor, 6 clocks at least.
// [RQ11] a pending bus request is serviced ahead of a pending interrupt.
// [RQ12] in normal unlocked execution the grant follows the request by 3-6 clocks (16-bit) or 3-10 clocks (8-bit).
// [RQ13] a request during a locked interrupt acknowledge is granted after 15 clocks.
// [RQ14] during a locked swap the grant is delayed 24-31 clocks (16-bit) or 24-39 clocks (8-bit).
// [RQ15] on the 16-bit variant an odd-address word operand stretches the upper bounds to 10 and 39 clocks.
// [RQ16] the request/grant mechanism exists only when the configuration strap is tied low.
// [RQ17] every pulse is active low and one clock wide; between pulses the line floats high.
package handover_pkg;
  typedef enum logic [2:0] {
    ST_OWN = 3'b000,
    ST_WAIT = 3'b001,
    ST_GRANT = 3'b010,
    ST_HELD = 3'b011,
    ST_XFER = 3'b100
  } arb_state_type;
  localparam logic [5:0] LAT_MIN = 6'h03;
  localparam logic [5:0] LAT_NORM16 = 6'h06;
  localparam logic [5:0] LAT_NORM8 = 6'h0a;
  localparam logic [5:0] LAT_ODD16 = 6'h0a;
  localparam logic [5:0] LAT_ACK = 6'h0f;
  localparam logic [5:0] LAT_SWAP_MIN = 6'h18;
  localparam logic [5:0] LAT_SWAP16 = 6'h1f;
  localparam logic [5:0] LAT_SWAP8 = 6'h27;
  localparam logic [5:0] LAT_SWAP_ODD = 6'h27;
  localparam logic [1:0] XFER_DELAY = 2'h1;
endpackage : handover_pkg

// ---- pulse_catch.sv ----
`timescale 1ns/100ps
// catches an active-low one-clock pulse on a shared line
// assumes the line level is synchronous to clk
module pulse_catch (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // line
  input wire logic line_in,
  output logic pulse
);
  logic prev_r;
  // [RQ17] falling edge marks a pulse
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prev_r <= 1'b1;
    end else begin
      prev_r <= line_in;
    end
  end
  // [RQ8] sampled on common clock
  assign pulse = prev_r & ~line_in;
endmodule : pulse_catch

// ---- bus_handover.sv ----
`timescale 1ns/100ps
// cpu-side request/grant arbiter for two handover lines
// assumes both masters share clk; lines are open-drain, pulled high outside
module bus_handover #(
  parameter bit WIDE_BUS = 1'b1
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // configuration
  input wire logic configuration_strap,
  // cpu bus status
  input wire logic bus_cycle_end,
  input wire logic bus_idle,
  input wire logic locked_ack,
  input wire logic locked_swap,
  input wire logic odd_word,
  input wire logic irq_pending,
  input wire logic execution_unit_needs_bus,
  input wire logic queue_empty,
  // handover lines
  input wire logic handover_line_high_priority_in,
  output logic handover_line_high_priority_out,
  output logic handover_line_high_priority_oe,
  input wire logic handover_line_low_priority_in,
  output logic handover_line_low_priority_out,
  output logic handover_line_low_priority_oe,
  // cpu side
  output logic bus_float,
  output logic decoder_detach,
  output logic irq_take,
  output logic execution_unit_stall,
  output logic bus_takeover_acknowledge
);
  handover_pkg::arb_state_type state_r;
  logic [1:0] pend_r;
  logic owner_r;
  logic [5:0] wait_r;
  logic [5:0] floor_r;
  logic [1:0] xfer_r;
  logic grant_ok;
  logic [1:0] pulse;
  logic [1:0] req_seen;
  logic rel;
  logic max_mode;

  // [RQ16] mechanism only with strap low
  assign max_mode = ~configuration_strap;

  pulse_catch u_hi (.clk(clk), .sys_rst(sys_rst), .line_in(handover_line_high_priority_in), .pulse(pulse[0]));
  pulse_catch u_lo (.clk(clk), .sys_rst(sys_rst), .line_in(handover_line_low_priority_in), .pulse(pulse[1]));

  // [RQ17] own grant not a request
  // the cpu's grant pulls the line low too; without this mask it would re-arm its own request
  assign req_seen = pulse & ~{handover_line_low_priority_oe, handover_line_high_priority_oe};

  // [RQ7] release pulse from the current owner
  assign rel = (state_r == handover_pkg::ST_HELD) && pulse[owner_r];
  // [RQ4] grant only at cycle end or idle, and not before the latency floor
  assign grant_ok = (bus_cycle_end || bus_idle) && (wait_r >= floor_r);

  // [RQ3] pending requests latched except from the line holding the bus, set wins over clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pend_r <= 2'h0;
    end else if (!max_mode) begin
      pend_r <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (req_seen[i] && !(state_r == handover_pkg::ST_HELD && owner_r == i[0])) begin
          pend_r[i] <= 1'b1;
        end else if (state_r == handover_pkg::ST_GRANT && owner_r == i[0]) begin
          pend_r[i] <= 1'b0;
        end
      end
    end
  end

  // [RQ12] latency counter; floor set by lock state on request
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wait_r <= 6'h00;
      floor_r <= handover_pkg::LAT_MIN;
    end else if (state_r == handover_pkg::ST_OWN || state_r == handover_pkg::ST_XFER) begin
      wait_r <= 6'h01;
      // [RQ13] locked acknowledge holds grant to 15 clocks
      if (locked_ack) begin
        floor_r <= handover_pkg::LAT_ACK;
      // [RQ14] locked swap holds grant to 24 clocks at least
      end else if (locked_swap) begin
        floor_r <= handover_pkg::LAT_SWAP_MIN;
      end else begin
        floor_r <= handover_pkg::LAT_MIN;
      end
    end else if (wait_r != 6'h3f) begin
      wait_r <= wait_r + 6'h01;
    end
  end

  // [RQ2] three-phase sequence
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= handover_pkg::ST_OWN;
      owner_r <= 1'b0;
      xfer_r <= 2'h0;
    end else begin
      case (state_r)
        handover_pkg::ST_OWN: begin
          // [RQ9] line 0 first
          if (max_mode && (pend_r[0] || req_seen[0])) begin
            owner_r <= 1'b0;
            state_r <= handover_pkg::ST_WAIT;
          end else if (max_mode && (pend_r[1] || req_seen[1])) begin
            owner_r <= 1'b1;
            state_r <= handover_pkg::ST_WAIT;
          end
        end
        handover_pkg::ST_WAIT: begin
          if (grant_ok) begin
            state_r <= handover_pkg::ST_GRANT;
          end
        end
        handover_pkg::ST_GRANT: begin
          state_r <= handover_pkg::ST_HELD;
        end
        handover_pkg::ST_HELD: begin
          if (rel) begin
            // [RQ10] waiting line 1 served after a short transfer gap
            if (owner_r == 1'b0 && pend_r[1]) begin
              state_r <= handover_pkg::ST_XFER;
              xfer_r <= handover_pkg::XFER_DELAY;
            end else begin
              state_r <= handover_pkg::ST_OWN;
            end
          end
        end
        handover_pkg::ST_XFER: begin
          if (xfer_r == 2'h0) begin
            owner_r <= 1'b1;
            state_r <= handover_pkg::ST_WAIT;
          end else begin
            xfer_r <= xfer_r - 2'h1;
          end
        end
        default: begin
          state_r <= handover_pkg::ST_OWN;
        end
      endcase
    end
  end

  // [RQ17] one-clock low grant pulse on owner line only
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      handover_line_high_priority_oe <= 1'b0;
      handover_line_low_priority_oe <= 1'b0;
    end else begin
      handover_line_high_priority_oe <= (state_r == handover_pkg::ST_WAIT) && grant_ok && !owner_r;
      handover_line_low_priority_oe <= (state_r == handover_pkg::ST_WAIT) && grant_ok && owner_r;
    end
  end

  // driven value is always low; oe alone makes the pulse
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      handover_line_high_priority_out <= 1'b0;
      handover_line_low_priority_out <= 1'b0;
    end else begin
      handover_line_high_priority_out <= 1'b0;
      handover_line_low_priority_out <= 1'b0;
    end
  end

  // [RQ5] float with grant, detach one clock later
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bus_float <= 1'b0;
      decoder_detach <= 1'b0;
      bus_takeover_acknowledge <= 1'b0;
    end else begin
      bus_float <= ((state_r == handover_pkg::ST_WAIT) && grant_ok) || (state_r == handover_pkg::ST_GRANT)
                   || ((state_r == handover_pkg::ST_HELD) && !rel);
      decoder_detach <= (state_r == handover_pkg::ST_GRANT) || ((state_r == handover_pkg::ST_HELD) && !rel);
      // [RQ1] acknowledge level while the bus is handed over
      bus_takeover_acknowledge <= (state_r == handover_pkg::ST_GRANT) || ((state_r == handover_pkg::ST_HELD) && !rel);
    end
  end

  // [RQ6] execution unit runs on from the queue while held
  // [RQ11] interrupts wait behind any bus request
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      execution_unit_stall <= 1'b0;
      irq_take <= 1'b0;
    end else begin
      execution_unit_stall <= (state_r != handover_pkg::ST_OWN) && (execution_unit_needs_bus || queue_empty);
      irq_take <= irq_pending && (state_r == handover_pkg::ST_OWN) && !(|pend_r) && !(|req_seen);
    end
  end

  // latency ceiling for checking
  logic [5:0] ceil_lat;
  // [RQ15] odd word stretches ceilings
  always_comb begin
    if (floor_r == handover_pkg::LAT_ACK) begin
      ceil_lat = handover_pkg::LAT_ACK;
    end else if (floor_r == handover_pkg::LAT_SWAP_MIN) begin
      ceil_lat = WIDE_BUS ? (odd_word ? handover_pkg::LAT_SWAP_ODD : handover_pkg::LAT_SWAP16)
                          : handover_pkg::LAT_SWAP8;
    end else begin
      ceil_lat = WIDE_BUS ? (odd_word ? handover_pkg::LAT_ODD16 : handover_pkg::LAT_NORM16)
                          : handover_pkg::LAT_NORM8;
    end
  end

  // only idle clocks are bounded: a stretched bus cycle may legally push the grant past the ceiling
  lat_ceiling_a: assert property (@(posedge clk) disable iff (sys_rst) // [RQ15]
    (state_r == handover_pkg::ST_WAIT) && bus_idle && (wait_r >= ceil_lat) |-> grant_ok)
    else $error("grant later than latency ceiling");

  grant_single_a: assert property (@(posedge clk) disable iff (sys_rst)
    !(handover_line_high_priority_oe && handover_line_low_priority_oe)) else $error("both lines driven"); // [RQ9]
  grant_width_a: assert property (@(posedge clk) disable iff (sys_rst)
    handover_line_high_priority_oe |=> !handover_line_high_priority_oe) else $error("grant wider than one clock"); // [RQ17]
  detach_after_a: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(handover_line_high_priority_oe) |=> decoder_detach) else $error("no detach after grant"); // [RQ5]
  float_grant_a: assert property (@(posedge clk) disable iff (sys_rst)
    handover_line_low_priority_oe |-> bus_float) else $error("grant without float"); // [RQ5]
  retake_bus_a: assert property (@(posedge clk) disable iff (sys_rst)
    rel && !pend_r[1] |=> ##1 !bus_float) else $error("bus not retaken after release"); // [RQ7]
  strap_off_a: assert property (@(posedge clk) disable iff (sys_rst)
    configuration_strap |-> ##1 (pend_r == 2'h0)) else $error("request held with strap high"); // [RQ16]
  grant_floor_a: assert property (@(posedge clk) disable iff (sys_rst)
    (state_r == handover_pkg::ST_WAIT && grant_ok) |-> wait_r >= handover_pkg::LAT_MIN)
    else $error("grant before three clocks"); // [RQ12]
  irq_behind_a: assert property (@(posedge clk) disable iff (sys_rst)
    (|pend_r) |=> !irq_take) else $error("interrupt ahead of bus request"); // [RQ11]
  xfer_gap_a: assert property (@(posedge clk) disable iff (sys_rst)
    state_r == handover_pkg::ST_XFER |-> ##2 state_r == handover_pkg::ST_WAIT) else $error("transfer gap wrong"); // [RQ10]
endmodule : bus_handover

// ---- bus_requester.sv ----
// behavioural requesting master on one request/grant line
// assumes the line is pulled high outside and shares clk with the cpu
`timescale 1ns/100ps
module bus_requester (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // commands from the bench
  input wire logic start,
  input wire logic release_bus,
  // line
  input wire logic line_in,
  output logic req_r,
  output logic rel_r,
  output logic owns_r
);
  logic wait_r;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      req_r <= 1'b0;
    end else begin
      req_r <= start && !owns_r && !wait_r && !req_r;
    end
  end
  // grant is a low line we do not pull
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wait_r <= 1'b0;
      owns_r <= 1'b0;
    end else if (req_r) begin
      wait_r <= 1'b1;
    end else if (wait_r && !line_in) begin
      wait_r <= 1'b0;
      owns_r <= 1'b1;
    end else if (release_bus && owns_r) begin
      owns_r <= 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    rel_r <= !sys_rst && release_bus && owns_r;
  end
endmodule : bus_requester

// ---- tb_top.sv ----
// testbench for the request/grant arbiter with two requesting masters
// assumes lines are open-drain with pull-ups, modelled by the assigns below
`timescale 1ns/100ps
module tb_top;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic strap = 1'b0, cyc_end = 1'b0, idle = 1'b1, l_ack = 1'b0, l_swap = 1'b0, odd = 1'b0;
  logic irq = 1'b0, needs = 1'b0, qe = 1'b0;
  logic [1:0] start = 2'b00, rel = 2'b00;
  logic [1:0] req, relp, own, oe, outv, line;
  logic flt, det, irq_take, stall, ack;
  int num_errors = 0, samples_checked = 0, cyc = 0, t0 = 0, tg = 0, tick = 0, lat;
  typedef struct {logic a; logic s; logic o; int lo; int hi;} row_type;
  // ack, swap, odd word, shortest and longest latency on the wide bus
  row_type rows [5] = '{'{1'b0, 1'b0, 1'b0, 3, 6}, '{1'b0, 1'b0, 1'b1, 3, 10}, '{1'b1, 1'b0, 1'b0, 15, 15},
    '{1'b0, 1'b1, 1'b0, 24, 31}, '{1'b0, 1'b1, 1'b1, 24, 39}};
  always #20 clk = ~clk;
  assign line[0] = !((oe[0] && !outv[0]) || req[0] || relp[0]);
  assign line[1] = !((oe[1] && !outv[1]) || req[1] || relp[1]);
  bus_handover #(.WIDE_BUS(1'b1)) dut (.clk(clk), .sys_rst(sys_rst), .configuration_strap(strap),
    .bus_cycle_end(cyc_end), .bus_idle(idle), .locked_ack(l_ack), .locked_swap(l_swap), .odd_word(odd),
    .irq_pending(irq), .execution_unit_needs_bus(needs), .queue_empty(qe),
    .handover_line_high_priority_in(line[0]), .handover_line_high_priority_out(outv[0]),
    .handover_line_high_priority_oe(oe[0]), .handover_line_low_priority_in(line[1]),
    .handover_line_low_priority_out(outv[1]), .handover_line_low_priority_oe(oe[1]),
    .bus_float(flt), .decoder_detach(det), .irq_take(irq_take), .execution_unit_stall(stall),
    .bus_takeover_acknowledge(ack));
  bus_requester m0 (.clk(clk), .sys_rst(sys_rst), .start(start[0]), .release_bus(rel[0]), .line_in(line[0]),
    .req_r(req[0]), .rel_r(relp[0]), .owns_r(own[0]));
  bus_requester m1 (.clk(clk), .sys_rst(sys_rst), .start(start[1]), .release_bus(rel[1]), .line_in(line[1]),
    .req_r(req[1]), .rel_r(relp[1]), .owns_r(own[1]));
  // stamps of the request pulse and the grant pulse on the high-priority line
  always @(negedge clk) begin
    cyc++;
    if (req[0]) t0 = cyc;
    if (oe[0]) tg = cyc;
  end
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic pulse(input int i, input bit r);
    @(negedge clk);
    if (r) rel[i] = 1'b1;
    else start[i] = 1'b1;
    @(negedge clk);
    rel[i] = 1'b0;
    start[i] = 1'b0;
  endtask : pulse
  // bounded wait: a missing grant shows up as a failed compare, not a hang
  task automatic wait_own(input int i, input int lim);
    repeat (lim) begin
      if (own[i]) break;
      @(negedge clk);
    end
  endtask : wait_own
  task automatic complete_run;
    if (num_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run
  always @(posedge clk) begin
    tick++;
    if (tick == 5000) begin
      num_errors++;
      complete_run();
    end
  end
  initial begin
    repeat (5) @(negedge clk);
    check("idle_rst", {2'h0, outv, oe, flt, det}, 8'h00);
    sys_rst = 1'b0;
    repeat (2) @(negedge clk);
    foreach (rows[k]) begin
      l_ack = rows[k].a;
      l_swap = rows[k].s;
      odd = rows[k].o;
      pulse(0, 1'b0);
      wait_own(0, 60);
      lat = tg - t0 - 1;
      check("latency", {7'h0, lat >= rows[k].lo && lat <= rows[k].hi}, 8'h01);
      check("held", {5'h0, flt, det, ack}, 8'h07);
      needs = 1'b1;
      repeat (2) @(negedge clk);
      check("stall", {7'h0, stall}, 8'h01);
      needs = 1'b0;
      repeat (2) @(negedge clk);
      check("run", {7'h0, stall}, 8'h00);
      pulse(0, 1'b1);
      repeat (2) @(negedge clk);
      check("back", {6'h0, flt, det}, 8'h00);
    end
    l_ack = 1'b0;
    l_swap = 1'b0;
    odd = 1'b0;
    irq = 1'b1;
    @(negedge clk);
    start = 2'b11;
    @(negedge clk);
    start = 2'b00;
    repeat (2) @(negedge clk);
    check("irq_held", {7'h0, irq_take}, 8'h00);
    wait_own(0, 60);
    check("winner", {6'h0, own}, 8'h01);
    pulse(0, 1'b1);
    wait_own(1, 12);
    check("second", {6'h0, own}, 8'h02);
    pulse(1, 1'b1);
    repeat (4) @(negedge clk);
    check("irq_free", {7'h0, irq_take}, 8'h01);
    irq = 1'b0;
    idle = 1'b0;
    pulse(0, 1'b0);
    repeat (30) @(negedge clk);
    check("mid_cycle", {6'h0, own}, 8'h00);
    cyc_end = 1'b1;
    @(negedge clk);
    cyc_end = 1'b0;
    wait_own(0, 4);
    check("cycle_end", {6'h0, own}, 8'h01);
    pulse(0, 1'b1);
    idle = 1'b1;
    strap = 1'b1;
    repeat (3) @(negedge clk);
    pulse(0, 1'b0);
    repeat (40) @(negedge clk);
    check("strap_high", {4'h0, oe, own}, 8'h00);
    sys_rst = 1'b1;
    repeat (5) @(negedge clk);
    check("idle_rst2", {2'h0, outv, oe, flt, det}, 8'h00);
    complete_run();
  end
endmodule : tb_top
